// >>> design/disp_port_if.sv
// Purpose: pins between host and display controller
// Assumes: one 200 MHz clock shared by both ends
// Notes:   data bus and serial data are two-way; wire level resolved here
`timescale 1ns/100ps
interface disp_port_if;
  logic        hw_reset_n;
  logic        chip_select_n;
  logic        cmd_data_select;
  logic        write_strobe_n;
  logic        read_strobe_n;
  logic        scl;
  logic [17:0] host_d;
  logic        host_d_oe;
  logic [17:0] dev_d;
  logic        dev_d_oe;
  logic        host_sda;
  logic        host_sda_oe;
  logic        dev_sda;
  logic        dev_sda_oe;
  wire  [17:0] d_bus;
  wire         sda;

  assign d_bus = host_d_oe ? host_d : (dev_d_oe ? dev_d : 18'h00000);
  assign sda   = host_sda_oe ? host_sda : (dev_sda_oe ? dev_sda : 1'b1);

  modport host (output hw_reset_n, chip_select_n, cmd_data_select, write_strobe_n, read_strobe_n, scl,
                output host_d, host_d_oe, host_sda, host_sda_oe, input d_bus, sda);
  modport device (input hw_reset_n, chip_select_n, cmd_data_select, write_strobe_n, read_strobe_n, scl,
                  output dev_d, dev_d_oe, dev_sda, dev_sda_oe, input d_bus, sda);
endinterface

// >>> design/disp_reset_dev.sv
// Purpose: display controller end: reset filtering, reload, blanking, readiness
// Assumes: pins are asynchronous to i_clk and are synchronised here
// Notes:   serial decode kept to byte capture; the host keeps pacing
// Overview of operation
// - ignore reset pulse under 5us, honour over 9us
// - spikes inside reset pulse are filtered too
// - reload settings from NVM at each release
// - blank display while resetting, then defaults
// - sleep-in reset cancel ends within 5ms
// - sleep-out reset cancel ends within 120ms
// - host waits 5ms before any command
// - host waits 120ms before sleep-out
// - host picks 18/16/9/8 bit bus
// - frame memory read uses slow pacing
// - ID read: 160ns cycle, 45ns phases
// - serial write clock 66ns, 15ns phases
// - serial read clock 150ns, 60ns phases
`timescale 1ns/100ps
module disp_reset_dev
  import rst_seq_pkg::*;
#(
  parameter int REJECT    = rst_seq_pkg::REJECT_CYC,
  parameter int ACCEPT    = rst_seq_pkg::ACCEPT_CYC,
  parameter int NVM_LOAD  = rst_seq_pkg::NVM_LOAD_CYC,
  parameter int BLANK     = rst_seq_pkg::BLANK_CYC
)(
  // system
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  // pins
  disp_port_if.device                 port,
  // user side
  input  wire logic                   i_sleep_out,
  input  wire rst_seq_pkg::link_mode_t i_mode,
  input  wire logic [17:0]            i_read_data,
  output logic                        o_in_reset,
  output logic                        o_blank,
  output logic                        o_nvm_load,
  output logic                        o_ready,
  output logic                        o_byte_valid,
  output logic [8:0]                  o_byte,
  output logic                        o_byte_is_data
);
  import rst_seq_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_RESET, ST_CANCEL} seq_t;

  // two-flop synchronisers for the six pins read here; write strobe and data bus are not synchronised
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      // scl idles low; a high reset value would look like a clock edge
      s1_q <= 6'h3b;
      s2_q <= 6'h3b;
    end
    else
    begin
      s1_q <= {port.hw_reset_n, port.chip_select_n, port.cmd_data_select, port.scl, port.sda, port.read_strobe_n};
      s2_q <= s1_q;
    end
  end
  wire rst_pin  = s2_q[5];
  wire cs_n     = s2_q[4];
  wire dcx      = s2_q[3];
  wire scl      = s2_q[2];
  wire sda_in   = s2_q[1];
  wire rd_n     = s2_q[0];

  // low-time integrator: counts up while low, down while high, so short
  // spikes inside a valid pulse cannot cancel it
  logic [CNT_W-1:0] low_q;
  logic             rst_act_q;
  wire              low_sat = (low_q == CNT_W'(ACCEPT));
  wire              at_zero = (low_q == '0);
  wire [CNT_W-1:0]  low_d   = !rst_pin ? (low_sat ? low_q : low_q + 1'b1)
                                      : (at_zero ? low_q : low_q - 1'b1);
  // take reset at 9us of net low; under 5us net low never asserts
  wire              go_rst  = !rst_pin && (low_q >= CNT_W'(ACCEPT - 1));
  wire              release_ev = rst_act_q && at_zero && rst_pin;

  seq_t             st_q;
  logic [CNT_W-1:0] tmr_q;
  logic             sleep_out_q;
  logic             was_awake_q;
  logic             ready_q;
  wire [CNT_W-1:0]  cancel_len = was_awake_q ? CNT_W'(BLANK) : CNT_W'(NVM_LOAD);
  // limit counts from the pin's release, so sync and drain time come out of it
  wire              cancel_end = (tmr_q >= cancel_len - CNT_W'(PIN_LAG_CYC));

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      low_q       <= '0;
      rst_act_q   <= 1'b0;
      st_q        <= ST_RUN;
      tmr_q       <= '0;
      sleep_out_q <= 1'b0;
      was_awake_q <= 1'b0;
      ready_q     <= 1'b1;
    end
    else
    begin
      low_q <= low_d;
      if (go_rst)
        rst_act_q <= 1'b1;
      else if (release_ev)
        rst_act_q <= 1'b0;
      sleep_out_q <= (st_q == ST_RUN) ? i_sleep_out : 1'b0;
      case (st_q)
        ST_RUN:
        begin
          if (go_rst)
          begin
            st_q        <= ST_RESET;
            tmr_q       <= '0;
            was_awake_q <= sleep_out_q;
            ready_q     <= 1'b0;
          end
        end
        ST_RESET:
        begin
          // a low spike while draining restarts the release time
          tmr_q <= rst_pin ? tmr_q + 1'b1 : '0;
          if (release_ev)
            st_q <= ST_CANCEL;
        end
        ST_CANCEL:
        begin
          tmr_q <= tmr_q + 1'b1;
          if (go_rst)
          begin
            st_q  <= ST_RESET;
            tmr_q <= '0;
          end
          else if (cancel_end)
          begin
            st_q        <= ST_RUN;
            ready_q     <= 1'b1;
            was_awake_q <= 1'b0;
          end
        end
        default:
          st_q <= ST_RUN;
      endcase
    end
  end

  assign o_in_reset = (st_q != ST_RUN);
  // reload runs during the first 5ms after every release
  assign o_nvm_load = (st_q == ST_CANCEL) && (tmr_q < CNT_W'(NVM_LOAD));
  assign o_blank    = (st_q != ST_RUN);
  assign o_ready    = ready_q;

  // serial byte capture; 3-line carries the d/c flag as first bit
  logic       scl_d_q;
  logic [8:0] sh_q;
  logic [3:0] bits_q;
  logic       bv_q;
  logic [8:0] byte_q;
  logic       isdata_q;
  wire        scl_rise = scl && !scl_d_q;
  wire        ser      = (i_mode != MODE_PAR);
  wire [3:0]  frame_len = (i_mode == MODE_SER3) ? 4'h9 : 4'h8;
  wire [8:0]  sh_next  = {sh_q[7:0], sda_in};

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      scl_d_q  <= 1'b0;
      sh_q     <= '0;
      bits_q   <= '0;
      bv_q     <= 1'b0;
      byte_q   <= '0;
      isdata_q <= 1'b0;
    end
    else
    begin
      scl_d_q <= scl;
      bv_q    <= 1'b0;
      if (cs_n || !ready_q || !ser)
        bits_q <= '0;
      else if (scl_rise)
      begin
        sh_q <= sh_next;
        if (bits_q == frame_len - 1'b1)
        begin
          bits_q   <= '0;
          bv_q     <= 1'b1;
          byte_q   <= {1'b0, sh_next[7:0]};
          isdata_q <= (i_mode == MODE_SER3) ? sh_next[8] : dcx;
        end
        else
          bits_q <= bits_q + 1'b1;
      end
    end
  end
  assign o_byte_valid   = bv_q;
  assign o_byte         = byte_q;
  assign o_byte_is_data = isdata_q;

  // parallel read return, driven while chip select and read strobe are low
  assign port.dev_d      = i_read_data;
  assign port.dev_d_oe   = !cs_n && !rd_n && (i_mode == MODE_PAR);
  assign port.dev_sda    = 1'b0;
  assign port.dev_sda_oe = 1'b0;
endmodule

// >>> design/disp_reset_host.sv
// Purpose: host end: drives reset pin, waits, paces bus strobes
// Assumes: single clock; device answers on the same wires
// Notes:   one transfer at a time; request taken only when idle
`timescale 1ns/100ps
module disp_reset_host
  import rst_seq_pkg::*;
#(
  parameter int RST_LOW   = rst_seq_pkg::ACCEPT_CYC + 2,
  parameter int CMD_WAIT  = rst_seq_pkg::NVM_LOAD_CYC,
  parameter int SLP_WAIT  = rst_seq_pkg::BLANK_CYC
)(
  // system
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  // pins
  disp_port_if.host                    port,
  // user side
  input  wire logic                    i_reset_req,
  input  wire logic                    i_req,
  input  wire rst_seq_pkg::xfer_kind_t i_kind,
  input  wire rst_seq_pkg::bus_width_t i_width,
  input  wire logic                    i_is_data,
  input  wire logic                    i_is_sleep_out,
  input  wire logic [17:0]             i_wdata,
  output logic                         o_busy,
  output logic                         o_cmd_ok,
  output logic                         o_sleep_ok,
  output logic                         o_done,
  output logic [17:0]                  o_rdata
);
  import rst_seq_pkg::*;

  typedef enum logic [1:0] {H_RESET, H_IDLE, H_SETUP, H_STROBE} hst_t;

  function automatic logic [17:0] width_mask(input bus_width_t w);
    case (w)
      BUS_W8:  width_mask = 18'h000ff;
      BUS_W9:  width_mask = 18'h001ff;
      BUS_W16: width_mask = 18'h0ffff;
      default: width_mask = 18'h3ffff;
    endcase
  endfunction

  hst_t             st_q;
  logic [CNT_W-1:0] since_q;
  logic [8:0]       t_q;
  xfer_kind_t       kind_q;
  logic [17:0]      wd_q;
  logic             dc_q;
  logic [17:0]      rd_q;
  logic             done_q;
  bus_width_t       width_q;
  // own counter: a reset after a long transfer still gets its full low time
  logic [CNT_W-1:0] rl_q;

  wire cmd_ok   = (since_q >= CNT_W'(CMD_WAIT));
  wire sleep_ok = (since_q >= CNT_W'(SLP_WAIT));
  wire accept   = (st_q == H_IDLE) && i_req && cmd_ok && (!i_is_sleep_out || sleep_ok);
  // setup, low and total counts per transfer kind
  wire [8:0] cs_len  = (kind_q == XF_READ_FM) ? 9'(FM_CS_CYC)    : (kind_q == XF_READ_ID) ? 9'(ID_CS_CYC) : 9'h001;
  wire [8:0] low_len = (kind_q == XF_READ_FM) ? 9'(FM_LOW_CYC)   : (kind_q == XF_READ_ID) ? 9'(ID_LOW_CYC) : 9'(WR_PHASE_CYC);
  wire [8:0] cyc_len = (kind_q == XF_READ_FM) ? 9'(FM_CYCLE_CYC) : (kind_q == XF_READ_ID) ? 9'(ID_CYCLE_CYC) : 9'(WR_CYCLE_CYC);
  wire       reading = (kind_q != XF_WRITE);

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_q    <= H_RESET;
      since_q <= '0;
      t_q     <= '0;
      kind_q  <= XF_WRITE;
      wd_q    <= '0;
      dc_q    <= 1'b0;
      rd_q    <= '0;
      done_q  <= 1'b0;
      width_q <= BUS_W18;
      rl_q    <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      if (st_q == H_RESET || since_q == CNT_W'(SLP_WAIT))
        since_q <= (st_q == H_RESET) ? '0 : since_q;
      else
        since_q <= since_q + 1'b1;
      case (st_q)
        H_RESET:
        begin
          if (rl_q >= CNT_W'(RST_LOW))
          begin
            st_q <= H_IDLE;
            rl_q <= '0;
          end
          else
            rl_q <= rl_q + 1'b1;
        end
        H_IDLE:
        begin
          if (i_reset_req)
            st_q <= H_RESET;
          else if (accept)
          begin
            st_q   <= H_SETUP;
            t_q    <= '0;
            kind_q <= i_kind;
            wd_q   <= i_wdata & width_mask(i_width);
            dc_q   <= i_is_data;
            width_q <= i_width;
          end
        end
        H_SETUP:
        begin
          t_q <= t_q + 1'b1;
          if (t_q == cs_len - 1'b1)
          begin
            st_q <= H_STROBE;
            t_q  <= '0;
          end
        end
        H_STROBE:
        begin
          t_q <= t_q + 1'b1;
          if (t_q == low_len - 1'b1 && reading)
            rd_q <= port.d_bus & width_mask(width_q);
          if (t_q == cyc_len - 1'b1)
          begin
            st_q   <= H_IDLE;
            done_q <= 1'b1;
          end
        end
        default:
          st_q <= H_IDLE;
      endcase
    end
  end

  // reset pin held low long enough to pass the device filter
  assign port.hw_reset_n      = (st_q != H_RESET);
  wire   strobe_low           = (st_q == H_STROBE) && (t_q < low_len);
  assign port.chip_select_n   = !(st_q == H_SETUP || st_q == H_STROBE);
  assign port.cmd_data_select = dc_q;
  assign port.write_strobe_n  = !(strobe_low && !reading);
  assign port.read_strobe_n   = !(strobe_low && reading);
  assign port.scl             = 1'b0;
  assign port.host_d          = wd_q;
  assign port.host_d_oe       = !reading && !port.chip_select_n;
  assign port.host_sda        = 1'b0;
  assign port.host_sda_oe     = 1'b0;

  assign o_busy     = (st_q != H_IDLE);
  assign o_cmd_ok   = cmd_ok && (st_q != H_RESET);
  assign o_sleep_ok = sleep_ok && (st_q != H_RESET);
  assign o_done     = done_q;
  assign o_rdata    = rd_q;
endmodule

// >>> design/rst_seq_pkg.sv
// Purpose: shared constants for the display host port reset sequencer
// Assumes: 200 MHz system clock on both ends
// Notes:   times kept in their own units, cycle counts derived from them
package rst_seq_pkg;
  localparam int CLK_MHZ          = 200;
  localparam int CLK_PERIOD_NS    = 5;
  localparam int REJECT_US        = 5;
  localparam int ACCEPT_US        = 9;
  localparam int NVM_LOAD_MS      = 5;
  localparam int BLANK_MS         = 120;
  localparam int REJECT_CYC       = REJECT_US * CLK_MHZ;
  localparam int ACCEPT_CYC       = ACCEPT_US * CLK_MHZ;
  localparam int NVM_LOAD_CYC     = NVM_LOAD_MS * 1000 * CLK_MHZ;
  localparam int BLANK_CYC        = BLANK_MS * 1000 * CLK_MHZ;
  // host pacing, least times round up
  localparam int WR_CYCLE_NS      = 66;
  localparam int WR_PHASE_NS      = 15;
  localparam int ID_CYCLE_NS      = 160;
  localparam int ID_LOW_NS        = 45;
  localparam int ID_CS_NS         = 45;
  localparam int FM_CYCLE_NS      = 450;
  localparam int FM_LOW_NS        = 355;
  localparam int FM_CS_NS         = 355;
  localparam int SR_CYCLE_NS      = 150;
  localparam int SR_PHASE_NS      = 60;
  localparam int WR_CYCLE_CYC     = (WR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PHASE_CYC     = (WR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ID_CYCLE_CYC     = (ID_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ID_LOW_CYC       = (ID_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ID_CS_CYC        = (ID_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FM_CYCLE_CYC     = (FM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FM_LOW_CYC       = (FM_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FM_CS_CYC        = (FM_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SR_CYCLE_CYC     = (SR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SR_PHASE_CYC     = (SR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_W           = 18;
  localparam int CNT_W            = 26;
  // pin to timer lag: two sync flops, sampling edge, one edge for an unaligned pin
  localparam int PIN_LAG_CYC      = 4;

  typedef enum logic [1:0] {BUS_W8, BUS_W9, BUS_W16, BUS_W18} bus_width_t;
  typedef enum logic [1:0] {XF_WRITE, XF_READ_ID, XF_READ_FM} xfer_kind_t;
  typedef enum logic [1:0] {MODE_PAR, MODE_SER3, MODE_SER4} link_mode_t;
endpackage

// >>> verification/display_host_port_reset_seq_bench.sv
// Purpose: joins host and display ends, plus a hand-driven second display end
// Assumes: shortened counts 40/200/400 in the display ends, 42/200/400 in the host end
// Notes:   second end takes glitches and serial bytes the host cannot make
`timescale 1ns/100ps
module display_host_port_reset_seq_bench;
  import rst_seq_pkg::*;
  localparam int RST = 42, WAIT = 200, SLP = 400, ACC = 40, NVM = 200, BLK = 400;
  logic i_clk = 1'b0, i_resetn = 1'b0, reset_req = 1'b0, req = 1'b0, is_sleep = 1'b0;
  logic sleep_a = 1'b0, sleep_b = 1'b0, got_v = 1'b0, got_dc, pin_a;
  xfer_kind_t  kind = XF_WRITE;
  bus_width_t  width = BUS_W18;
  link_mode_t  mode_b = MODE_SER4;
  logic [17:0] rd_a = 18'h2a5c3, rdata, wr_seen;
  logic [8:0]  byte_b, got_byte;
  logic busy, cmd_ok, sleep_ok, done, in_rst_a, blank_a, nvm_a, rdy_a, in_rst_b, rdy_b, bv_b, bd_b;
  int n_mismatch = 0, n_compared = 0, cyc = 0, t_rise = 0, t_sleep = 0;
  disp_port_if port_a();
  disp_port_if port_b();
  assign pin_a = port_a.hw_reset_n;

  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  // write data on the wires and the first cycle the sleep gate opens
  always @(posedge i_clk)
  begin
    if (port_a.write_strobe_n === 1'b0)
      wr_seen <= port_a.d_bus;
    if (sleep_ok === 1'b1 && t_sleep == 0)
      t_sleep <= cyc;
  end
  always @(posedge i_clk)
  begin
    if (bv_b === 1'b1)
    begin
      got_v <= 1'b1;
      got_byte <= byte_b;
      got_dc <= bd_b;
    end
  end
  initial
  begin
    port_b.hw_reset_n = 1'b1;
    port_b.chip_select_n = 1'b1;
    port_b.cmd_data_select = 1'b1;
    port_b.write_strobe_n = 1'b1;
    port_b.read_strobe_n = 1'b1;
    port_b.scl = 1'b0;
    port_b.host_d = 18'h00000;
    port_b.host_d_oe = 1'b0;
    port_b.host_sda = 1'b1;
    port_b.host_sda_oe = 1'b1;
  end

  disp_reset_host #(.RST_LOW(RST), .CMD_WAIT(WAIT), .SLP_WAIT(SLP)) u_disp_reset_host (.i_clk(i_clk),
    .i_resetn(i_resetn), .port(port_a.host), .i_reset_req(reset_req), .i_req(req), .i_kind(kind),
    .i_width(width), .i_is_data(1'b1), .i_is_sleep_out(is_sleep), .i_wdata(18'h3a5c3), .o_busy(busy),
    .o_cmd_ok(cmd_ok), .o_sleep_ok(sleep_ok), .o_done(done), .o_rdata(rdata));
  disp_reset_dev #(.REJECT(20), .ACCEPT(ACC), .NVM_LOAD(NVM), .BLANK(BLK)) u_disp_reset_dev (.i_clk(i_clk),
    .i_resetn(i_resetn), .port(port_a.device), .i_sleep_out(sleep_a), .i_mode(MODE_PAR), .i_read_data(rd_a),
    .o_in_reset(in_rst_a), .o_blank(blank_a), .o_nvm_load(nvm_a), .o_ready(rdy_a), .o_byte_valid(),
    .o_byte(), .o_byte_is_data());
  disp_reset_dev #(.REJECT(20), .ACCEPT(ACC), .NVM_LOAD(NVM), .BLANK(BLK)) u_disp_reset_dev_b (.i_clk(i_clk),
    .i_resetn(i_resetn), .port(port_b.device), .i_sleep_out(sleep_b), .i_mode(mode_b), .i_read_data(18'h00000),
    .o_in_reset(in_rst_b), .o_blank(), .o_nvm_load(), .o_ready(rdy_b), .o_byte_valid(bv_b),
    .o_byte(byte_b), .o_byte_is_data(bd_b));
  display_host_port_reset_seq_properties #(.RST_LOW(RST), .CMD_WAIT(WAIT)) u_props (.i_clk(i_clk),
    .i_resetn(i_resetn), .hw_reset_n(port_a.hw_reset_n), .chip_select_n(port_a.chip_select_n),
    .write_strobe_n(port_a.write_strobe_n), .read_strobe_n(port_a.read_strobe_n));

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait; also notes whether nvm load or blanking was seen on the way
  task automatic wait_hi(ref logic s, output int n, output logic sn, output logic sb);
    n = 0;
    sn = 1'b0;
    sb = 1'b0;
    while (s !== 1'b1 && n < 2000)
    begin
      @(negedge i_clk);
      n++;
      sn |= (nvm_a === 1'b1);
      sb |= (blank_a === 1'b1);
    end
  endtask
  task automatic xfer(input xfer_kind_t k, input bus_width_t w, input logic s, output int n);
    logic sn, sb;
    kind = k;
    width = w;
    is_sleep = s;
    req = 1'b1;
    @(negedge i_clk);
    req = 1'b0;
    wait_hi(done, n, sn, sb);
  endtask
  function automatic logic [17:0] cut(input bus_width_t w, input logic [17:0] v);
    case (w)
      BUS_W8:  return {10'h000, v[7:0]};
      BUS_W9:  return {9'h000, v[8:0]};
      BUS_W16: return {2'h0, v[15:0]};
      default: return v;
    endcase
  endfunction

  task automatic t_power_up;
    int n;
    logic sn, sb;
    wait_hi(pin_a, n, sn, sb);
    t_rise = cyc;
    check(in_rst_a, 1'b1);
    check(blank_a, 1'b1);
    wait_hi(rdy_a, n, sn, sb);
    check(n < NVM && n + 8 > NVM, 1'b1);
    check(sn, 1'b1);
    wait_hi(cmd_ok, n, sn, sb);
    check(cyc - t_rise >= WAIT, 1'b1);
    check(sleep_ok, 1'b0);
    check(busy, 1'b0);
  endtask
  task automatic t_sleep_gate;
    int n;
    logic sn, sb;
    xfer(XF_WRITE, BUS_W8, 1'b1, n);
    check(n >= 2000, 1'b1);
    check(t_sleep - t_rise >= SLP && t_sleep - t_rise <= SLP + 1, 1'b1);
    xfer(XF_WRITE, BUS_W8, 1'b1, n);
    check(n < 400, 1'b1);
  endtask
  task automatic t_xfers;
    int n;
    bus_width_t ws[4] = '{BUS_W8, BUS_W9, BUS_W16, BUS_W18};
    for (int i = 0; i < 4; i++)
    begin
      xfer(XF_WRITE, ws[i], 1'b0, n);
      check(n >= WR_CYCLE_CYC && n < 400, 1'b1);
      check(wr_seen, cut(ws[i], 18'h3a5c3));
      xfer(XF_READ_ID, ws[i], 1'b0, n);
      check(rdata, cut(ws[i], rd_a));
      check(n >= ID_CYCLE_CYC && n < 400, 1'b1);
    end
    rd_a = 18'h15a3c;
    xfer(XF_READ_FM, BUS_W18, 1'b0, n);
    check(rdata, 18'h15a3c);
    check(n >= FM_CYCLE_CYC && n < 400, 1'b1);
  endtask
  task automatic t_rereset;
    int n;
    logic sn, sb;
    sleep_a = 1'b1;
    reset_req = 1'b1;
    @(negedge i_clk);
    reset_req = 1'b0;
    repeat (3) @(negedge i_clk);
    check(cmd_ok, 1'b0);
    wait_hi(pin_a, n, sn, sb);
    check(blank_a, 1'b1);
    wait_hi(rdy_a, n, sn, sb);
    check(n < BLK && n + 8 > BLK, 1'b1);
    check(sn, 1'b1);
  endtask
  task automatic pulse_b(input int lo);
    port_b.hw_reset_n = 1'b0;
    repeat (lo) @(negedge i_clk);
    port_b.hw_reset_n = 1'b1;
  endtask
  task automatic t_glitch;
    int n;
    logic sn, sb;
    pulse_b(15);
    repeat (30) @(negedge i_clk);
    check({in_rst_b, rdy_b}, 2'b01);
    pulse_b(25);
    repeat (3) @(negedge i_clk);
    pulse_b(25);
    check(in_rst_b, 1'b1);
    wait_hi(rdy_b, n, sn, sb);
    check(n < NVM && n + 8 > NVM, 1'b1);
  endtask
  // 15-cycle phases give a 150 ns period, slow enough for reads as well
  task automatic ser(input link_mode_t m, input logic [8:0] v, input int nb, input logic [8:0] eb, input logic ed);
    mode_b = m;
    got_v = 1'b0;
    port_b.chip_select_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--)
    begin
      port_b.host_sda = v[i];
      repeat (15) @(negedge i_clk);
      port_b.scl = 1'b1;
      repeat (15) @(negedge i_clk);
      port_b.scl = 1'b0;
    end
    repeat (15) @(negedge i_clk);
    port_b.chip_select_n = 1'b1;
    check({got_v, got_dc, got_byte}, {1'b1, ed, eb});
  endtask

  initial
  begin
    repeat (16) @(negedge i_clk);
    i_resetn = 1'b1;
    t_power_up;
    t_sleep_gate;
    t_xfers;
    t_rereset;
    t_glitch;
    ser(MODE_SER4, 9'h0a5, 8, 9'h0a5, 1'b1);
    port_b.cmd_data_select = 1'b0;
    ser(MODE_SER3, 9'h13c, 9, 9'h03c, 1'b1);
    report_and_stop;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop;
  end
endmodule

// >>> verification/display_host_port_reset_seq_properties.sv
// Purpose: wire checks between host end and display end
// Assumes: one clock; host owns reset pin, chip select and strobes
// Notes:   pulse lengths held in counters, repetition would unroll too far
`timescale 1ns/100ps
module display_host_port_reset_seq_properties
  import rst_seq_pkg::*;
#(
  parameter int RST_LOW  = 42,
  parameter int CMD_WAIT = 200
)(
  // system
  input wire logic i_clk,
  input wire logic i_resetn,
  // pins
  input wire logic hw_reset_n,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n
);
  import rst_seq_pkg::*;
  logic [15:0] low_q;
  logic [15:0] since_q;
  logic [15:0] wr_q;
  logic [15:0] rd_q;
  logic [15:0] cs_q;
  logic [15:0] gap_q;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      low_q   <= 16'h0000;
      since_q <= 16'h0000;
      wr_q    <= 16'h0000;
      rd_q    <= 16'h0000;
      cs_q    <= 16'h0000;
      gap_q   <= 16'h0000;
    end
    else
    begin
      low_q   <= hw_reset_n ? 16'h0000 : low_q + 16'h0001;
      since_q <= hw_reset_n ? since_q + 16'h0001 : 16'h0000;
      wr_q    <= write_strobe_n ? 16'h0000 : wr_q + 16'h0001;
      rd_q    <= read_strobe_n ? 16'h0000 : rd_q + 16'h0001;
      cs_q    <= chip_select_n ? 16'h0000 : cs_q + 16'h0001;
      gap_q   <= $fell(read_strobe_n) ? 16'h0001 : gap_q + 16'h0001;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_release;
    $rose(hw_reset_n);
  endsequence
  sequence s_quiet;
    chip_select_n [*8];
  endsequence

  a_release_quiet: assert property (s_release |-> s_quiet)
    else $error("chip select moved right after reset release");
  a_cmd_wait_kept: assert property (!chip_select_n |-> since_q >= CMD_WAIT - 1)
    else $error("command sent too soon after reset release");
  a_reset_pulse_long: assert property ($rose(hw_reset_n) |-> low_q >= RST_LOW)
    else $error("reset pulse too short");
  a_bus_idle_reset: assert property (!hw_reset_n |-> chip_select_n && write_strobe_n && read_strobe_n)
    else $error("bus active while reset pin low");
  a_strobe_in_cs: assert property ((!write_strobe_n || !read_strobe_n) |-> !chip_select_n)
    else $error("strobe low without chip select");
  a_write_low_min: assert property ($rose(write_strobe_n) |-> wr_q >= WR_PHASE_CYC)
    else $error("write strobe low too short");
  a_read_low_min: assert property ($rose(read_strobe_n) |-> rd_q >= ID_LOW_CYC)
    else $error("read strobe low too short");
  a_read_cs_setup: assert property ($fell(read_strobe_n) |-> cs_q >= ID_CS_CYC)
    else $error("chip select setup before read too short");
  a_read_cycle_min: assert property ($fell(read_strobe_n) |-> gap_q >= ID_CYCLE_CYC)
    else $error("read cycle too short");
endmodule
